/* File: rtl/bit_fifo.sv */
// Small FIFO between the stream producer and the shifter.
// Assumes one clock; push on in_valid&in_ready, pop on out_valid&out_ready.
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic push;
    logic pop;

    assign in_ready = (s_r.count != (AW+1)'(DEPTH));
    assign out_valid = (s_r.count != '0);
    assign out_data = s_r.mem[s_r.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = AW'(s_r.wr + 1'b1);
        end
        if (pop)
            s_nxt.rd = AW'(s_r.rd + 1'b1);
        if (push && !pop)
            s_nxt.count = (AW+1)'(s_r.count + 1'b1);
        else if (pop && !push)
            s_nxt.count = (AW+1)'(s_r.count - 1'b1);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule : bit_fifo

/* File: rtl/serial_gpio_shift_controller.sv */
// Serial expander: drives a chain of shift registers and reads it back.
// Assumes an APB master on clock and pins synchronised here.
`timescale 1ns/1ps
module serial_gpio_shift_controller
    import serial_position_pkg::*;
#(
    parameter int GAP_STEP_CYCLES = GAP_STEP_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chain_shift_clock,
    output logic chain_data_out,
    output logic chain_load_strobe,
    input wire logic chain_data_in,
    input wire logic [NUM_DETECTS-1:0] parallel_signal_detect_n,
    output logic [NUM_PORTS-1:0] loss_of_signal
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic single;
        logic repeat_on;
        logic [1:0] width_m1;
        logic gap_dis;
        logic [5:0] gap_len;
        logic ld_pol;
        logic rev_in;
        logic rev_out;
        logic [7:0] clk_div;
        logic [31:0] port_ena;
        logic [127:0] out_data;
        logic [127:0] in_data;
        logic [15:0][4:0] map_port;
        logic [15:0] map_ena;
        logic [31:0] los;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        shift_state_t st;
        logic [7:0] cnt;
        logic sclk;
        logic dout;
        logic ld;
        logic cur_last;
        logic [4:0] in_port;
        logic [1:0] in_bit;
        logic [5:0] gap_steps;
        logic [13:0] step_cnt;
        logic prod_active;
        logic [4:0] prod_port;
        logic [1:0] prod_bit;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    logic [16:0] pins_s;
    logic di_s;
    logic [NUM_DETECTS-1:0] sd_s;
    logic f_in_valid;
    logic f_in_ready;
    logic [1:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [1:0] f_out_data;

    // ----------------------------------------
    // Next enabled port in scan order
    // ----------------------------------------
    function automatic logic [5:0] next_port(input logic [31:0] ena, input logic [4:0] cur,
                                             input logic rev, input logic from_start);
        logic [5:0] res;
        logic [4:0] c;
        res = '0;
        for (int k = 0; k < NUM_PORTS; k++)
        begin
            c = rev ? 5'(NUM_PORTS - 1 - k) : 5'(k);
            if (ena[c] && !res[5] && (from_start || (rev ? (c < cur) : (c > cur))))
                res = {1'b1, c};
        end
        return res;
    endfunction : next_port

    // ----------------------------------------
    // Pin synchronisers and stream FIFO
    // ----------------------------------------
    sync_two #(.WIDTH(17)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({chain_data_in, parallel_signal_detect_n}),
        .sync_out(pins_s)
    );
    assign di_s = pins_s[16];
    assign sd_s = pins_s[15:0];

    bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    assign f_out_ready = (s_r.st == ST_WAIT);
    assign f_in_valid = s_r.prod_active;

    always_comb
    begin
        logic [5:0] np;
        logic [7:0] half;
        logic [5:0] idx;
        np = '0;
        half = '0;
        idx = '0;
        s_nxt = s_r;
        half = (s_r.clk_div < MIN_HALF) ? MIN_HALF : s_r.clk_div;

        // ----------------------------------------
        // Stream producer
        // ----------------------------------------
        np = next_port(s_r.port_ena, s_r.prod_port, s_r.rev_out, 1'b0);
        f_in_data = {(s_r.prod_bit == s_r.width_m1) && !np[5],
                     s_r.out_data[{s_r.prod_port, s_r.prod_bit}]};
        if (s_r.prod_active && f_in_ready)
        begin
            if (s_r.prod_bit == s_r.width_m1)
            begin
                s_nxt.prod_bit = 2'h0;
                s_nxt.prod_port = np[4:0];
                s_nxt.prod_active = np[5];
            end
            else
                s_nxt.prod_bit = 2'(s_r.prod_bit + 1'b1);
        end

        // ----------------------------------------
        // Shift engine
        // ----------------------------------------
        case (s_r.st)
            ST_IDLE:
            begin
                s_nxt.sclk = 1'b1;
                if (s_r.single || s_r.repeat_on)
                begin
                    np = next_port(s_r.port_ena, 5'h0, s_r.rev_out, 1'b1);
                    s_nxt.prod_port = np[4:0];
                    s_nxt.prod_bit = 2'h0;
                    s_nxt.prod_active = np[5];
                    np = next_port(s_r.port_ena, 5'h0, s_r.rev_in, 1'b1);
                    s_nxt.in_port = np[4:0];
                    s_nxt.in_bit = 2'h0;
                    if (np[5])
                        s_nxt.st = ST_WAIT;
                    else
                    begin
                        s_nxt.st = ST_LOAD;
                        s_nxt.cnt = 8'(LOAD_CYCLES - 1'b1);
                        s_nxt.ld = s_r.ld_pol;
                    end
                end
            end
            ST_WAIT:
            begin
                if (f_out_valid)
                begin
                    s_nxt.sclk = 1'b0;
                    s_nxt.dout = f_out_data[0];
                    s_nxt.cur_last = f_out_data[1];
                    s_nxt.cnt = 8'(half - 1'b1);
                    s_nxt.st = ST_LO;
                end
            end
            ST_LO:
            begin
                if (s_r.cnt == 8'h0)
                begin
                    s_nxt.sclk = 1'b1;
                    s_nxt.in_data[{s_r.in_port, s_r.in_bit}] = di_s;
                    if (s_r.in_bit == s_r.width_m1)
                    begin
                        np = next_port(s_r.port_ena, s_r.in_port, s_r.rev_in, 1'b0);
                        s_nxt.in_bit = 2'h0;
                        s_nxt.in_port = np[4:0];
                    end
                    else
                        s_nxt.in_bit = 2'(s_r.in_bit + 1'b1);
                    s_nxt.cnt = 8'(half - 1'b1);
                    s_nxt.st = ST_HI;
                end
                else
                    s_nxt.cnt = 8'(s_r.cnt - 1'b1);
            end
            ST_HI:
            begin
                if (s_r.cnt == 8'h0)
                begin
                    if (s_r.cur_last)
                    begin
                        s_nxt.st = ST_LOAD;
                        s_nxt.cnt = 8'(LOAD_CYCLES - 1'b1);
                        s_nxt.ld = s_r.ld_pol;
                    end
                    else
                        s_nxt.st = ST_WAIT;
                end
                else
                    s_nxt.cnt = 8'(s_r.cnt - 1'b1);
            end
            ST_LOAD:
            begin
                if (s_r.cnt == 8'h0)
                begin
                    s_nxt.ld = !s_r.ld_pol;
                    s_nxt.single = 1'b0;
                    if (s_r.repeat_on && !s_r.gap_dis && s_r.gap_len != 6'h0)
                    begin
                        s_nxt.st = ST_GAP;
                        s_nxt.gap_steps = s_r.gap_len;
                        s_nxt.step_cnt = 14'(GAP_STEP_CYCLES - 1);
                    end
                    else
                        s_nxt.st = ST_IDLE;
                end
                else
                    s_nxt.cnt = 8'(s_r.cnt - 1'b1);
            end
            ST_GAP:
            begin
                if (!s_r.repeat_on)
                    s_nxt.st = ST_IDLE;
                else if (s_r.step_cnt == 14'h0)
                begin
                    s_nxt.step_cnt = 14'(GAP_STEP_CYCLES - 1);
                    s_nxt.gap_steps = 6'(s_r.gap_steps - 1'b1);
                    if (s_r.gap_steps == 6'h1)
                        s_nxt.st = ST_IDLE;
                end
                else
                    s_nxt.step_cnt = 14'(s_r.step_cnt - 1'b1);
            end
            default:
                s_nxt.st = ST_IDLE;
        endcase

        // ----------------------------------------
        // Loss-of-signal forwarding
        // ----------------------------------------
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            s_nxt.los[p] = s_r.in_data[p * 4];
            for (int n = 0; n < NUM_DETECTS; n++)
            begin
                if (s_r.map_ena[n] && s_r.map_port[n] == 5'(p))
                    s_nxt.los[p] = sd_s[n];
            end
        end

        // ----------------------------------------
        // APB slave: decode in setup, answer in access
        // ----------------------------------------
        s_nxt.pready = psel && !penable;
        s_nxt.prdata = 32'h0;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable)
        begin
            idx = paddr[7:2] - ADDR_MAP_BASE[7:2];
            if (paddr == ADDR_CFG)
                s_nxt.prdata = 32'({s_r.rev_out, s_r.rev_in, s_r.ld_pol, s_r.gap_len,
                                    s_r.gap_dis, s_r.width_m1, s_r.repeat_on, s_r.single});
            else if (paddr == ADDR_CLOCK)
                s_nxt.prdata = 32'(s_r.clk_div);
            else if (paddr == ADDR_PORT_ENA)
                s_nxt.prdata = s_r.port_ena;
            else if (paddr == ADDR_STATUS)
                s_nxt.prdata = 32'(s_r.st != ST_IDLE);
            else if (paddr[7:4] == ADDR_OUT_BASE[7:4] && paddr[1:0] == 2'h0)
                s_nxt.prdata = s_r.out_data[paddr[3:2] * 32 +: 32];
            else if (paddr[7:4] == ADDR_IN_BASE[7:4] && paddr[1:0] == 2'h0)
                s_nxt.prdata = s_r.in_data[paddr[3:2] * 32 +: 32];
            else if (paddr == ADDR_LOS)
                s_nxt.prdata = s_r.los;
            else if (paddr[7:6] == ADDR_MAP_BASE[7:6] && paddr[1:0] == 2'h0)
                s_nxt.prdata = 32'({s_r.map_ena[idx[3:0]], 3'h0, s_r.map_port[idx[3:0]]});
            else
                s_nxt.pslverr = 1'b1;
            if (pwrite)
                s_nxt.prdata = 32'h0;
        end
        if (psel && penable && s_r.pready && pwrite && !s_r.pslverr)
        begin
            idx = paddr[7:2] - ADDR_MAP_BASE[7:2];
            if (paddr == ADDR_CFG)
            begin
                s_nxt.single = s_r.single | pwdata[CFG_SINGLE];
                s_nxt.repeat_on = pwdata[CFG_REPEAT];
                s_nxt.width_m1 = pwdata[CFG_WIDTH_LSB +: 2];
                s_nxt.gap_dis = pwdata[CFG_GAP_DIS];
                s_nxt.gap_len = pwdata[CFG_GAP_LSB +: 6];
                s_nxt.ld_pol = pwdata[CFG_LD_POL];
                s_nxt.rev_in = pwdata[CFG_REV_IN];
                s_nxt.rev_out = pwdata[CFG_REV_OUT];
                if (s_r.st != ST_LOAD)
                    s_nxt.ld = !pwdata[CFG_LD_POL];
            end
            else if (paddr == ADDR_CLOCK)
                s_nxt.clk_div = pwdata[7:0];
            else if (paddr == ADDR_PORT_ENA)
                s_nxt.port_ena = pwdata;
            else if (paddr[7:4] == ADDR_OUT_BASE[7:4])
                s_nxt.out_data[paddr[3:2] * 32 +: 32] = pwdata;
            else if (paddr[7:6] == ADDR_MAP_BASE[7:6])
            begin
                s_nxt.map_port[idx[3:0]] = pwdata[4:0];
                s_nxt.map_ena[idx[3:0]] = pwdata[MAP_ENA_BIT];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
            s_r.clk_div <= CLK_DIV_RST;
            s_r.ld_pol <= 1'b1;
            s_r.sclk <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign chain_shift_clock = s_r.sclk;
    assign chain_data_out = s_r.dout;
    assign chain_load_strobe = s_r.ld;
    assign loss_of_signal = s_r.los;

endmodule : serial_gpio_shift_controller

/* File: rtl/serial_position_pkg.sv */
// Constants, register map and types of the serial GPIO shift controller.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package serial_position_pkg;

    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int NUM_PORTS = 32;
    localparam int NUM_DETECTS = 16;
    localparam int CLK_PERIOD_NS = 100;
    localparam int LOAD_MIN_NS = 25;
    localparam int LOAD_CYCLES_CALC = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] LOAD_CYCLES = (LOAD_CYCLES_CALC < 1) ? 2'h1 : 2'(LOAD_CYCLES_CALC);
    localparam int GAP_STEP_US = 1000;
    localparam int GAP_STEP_CYCLES_DEF = GAP_STEP_US * 1000 / CLK_PERIOD_NS;
    localparam logic [7:0] MIN_HALF = 8'h03;
    localparam logic [7:0] CLK_DIV_RST = 8'h0A;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 2;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CLOCK = 8'h04;
    localparam logic [7:0] ADDR_PORT_ENA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_OUT_BASE = 8'h10;
    localparam logic [7:0] ADDR_IN_BASE = 8'h20;
    localparam logic [7:0] ADDR_LOS = 8'h30;
    localparam logic [7:0] ADDR_MAP_BASE = 8'h40;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int CFG_SINGLE = 0;
    localparam int CFG_REPEAT = 1;
    localparam int CFG_WIDTH_LSB = 2;
    localparam int CFG_GAP_DIS = 4;
    localparam int CFG_GAP_LSB = 5;
    localparam int CFG_LD_POL = 11;
    localparam int CFG_REV_IN = 12;
    localparam int CFG_REV_OUT = 13;
    localparam int MAP_ENA_BIT = 8;

    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_LO, ST_HI, ST_LOAD, ST_GAP} shift_state_t;

endpackage : serial_position_pkg

/* File: rtl/sync_two.sv */
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps
module sync_two #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    always_comb
    begin
        s_nxt.meta = async_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign sync_out = s_r.stable;
endmodule : sync_two

/* File: verification/serial_gpio_shift_controller_asserts.sv */
// Port checks for the serial expander.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module serial_gpio_shift_controller_asserts
    import serial_position_pkg::*;
#(
    parameter int GAP_STEP_CYCLES = GAP_STEP_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chain_shift_clock,
    input wire logic chain_data_out,
    input wire logic chain_load_strobe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ----
    // Register bus
    // ----
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("prdata nonzero on write");
    // ----
    // Chain pins
    // ----
    a_low_phase_min: assert property (
        $fell(chain_shift_clock) |=> !chain_shift_clock [*2])
        else $error("shift clock low phase short");
    a_high_phase_min: assert property (
        $rose(chain_shift_clock) |=> chain_shift_clock [*2])
        else $error("shift clock high phase short");
    a_data_on_fall: assert property (
        $changed(chain_data_out) |-> $fell(chain_shift_clock))
        else $error("data out moved off falling edge");
    a_load_clock_high: assert property (
        $changed(chain_load_strobe) |-> chain_shift_clock)
        else $error("load strobe moved while shifting");
    a_load_single_pulse: assert property (
        $changed(chain_load_strobe) ##1 $changed(chain_load_strobe)
        |=> $stable(chain_load_strobe))
        else $error("load strobe toggled again");
    c_load: cover property ($changed(chain_load_strobe));
    c_err: cover property (pslverr);
    c_shift: cover property ($fell(chain_shift_clock));
endmodule : serial_gpio_shift_controller_asserts

/* File: verification/serial_gpio_shift_controller_tb.sv */
// Self-checking bench for the serial expander and a chain model.
// Assumes a 10-cycle gap step and a 16-stage chain.
`timescale 1ns/1ps
module serial_gpio_shift_controller_tb;
    import serial_position_pkg::*;
    localparam int GAP_STEP = 10;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] parallel_signal_detect_n = 16'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic chain_shift_clock;
    logic chain_data_out;
    logic chain_load_strobe;
    logic chain_data_in;
    logic [31:0] loss_of_signal;
    logic load_active = 1'b1;
    logic [15:0] par_in = 16'h0;
    logic [15:0] par_out;
    logic ld_q = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    int falls = 0;
    int low_cycles = 0;
    int cyc = 0;
    int loads = 0;
    int t_last = 0;
    int t_prev = 0;
    always #50 clock = ~clock;
    serial_gpio_shift_controller #(.GAP_STEP_CYCLES(GAP_STEP)) serial_gpio_shift_controller_inst (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chain_shift_clock(chain_shift_clock), .chain_data_out(chain_data_out),
        .chain_load_strobe(chain_load_strobe), .chain_data_in(chain_data_in),
        .parallel_signal_detect_n(parallel_signal_detect_n), .loss_of_signal(loss_of_signal));
    shift_chain_model #(.LEN(16)) shift_chain_model_inst (
        .chain_shift_clock(chain_shift_clock), .chain_data_out(chain_data_out),
        .chain_load_strobe(chain_load_strobe), .load_active(load_active),
        .par_in(par_in), .chain_data_in(chain_data_in), .par_out(par_out));
    // ----
    // Pin monitors
    // ----
    always @(negedge chain_shift_clock) falls++;
    always @(posedge clock)
    begin
        cyc++;
        if (chain_shift_clock === 1'b0) low_cycles++;
        ld_q <= chain_load_strobe;
        if (chain_load_strobe === 1'b1 && ld_q === 1'b0)
        begin
            loads++;
            t_prev = t_last;
            t_last = cyc;
        end
    end
    // ----
    // Helpers
    // ----
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(name, exp, q);
    endtask : rd_chk
    task automatic wait_clear(input logic [7:0] a);
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && n < 300)
        begin
            apb(1'b0, a, 32'h0, q, e);
            n++;
        end
        if (n == 300) chk("idle", 32'h0, q);
    endtask : wait_clear
    task automatic wait_loads(input int n);
        int base;
        int k;
        base = loads;
        k = 0;
        while (loads < base + n && k < 3000)
        begin
            @(posedge clock);
            k++;
        end
        if (loads < base + n) chk("loads", 32'(base + n), 32'(loads));
    endtask : wait_loads
    // ----
    // Scenarios
    // ----
    task automatic t_reset_values;
        logic [31:0] q;
        logic e;
        rd_chk("cfg", ADDR_CFG, 32'h0000_0800);
        rd_chk("clock", ADDR_CLOCK, 32'h0000_000A);
        rd_chk("los", ADDR_LOS, 32'h0);
        apb(1'b0, 8'hFC, 32'h0, q, e);
        chk("slverr", 32'h1, {31'h0, e});
        chk("bad read", 32'h0, q);
    endtask : t_reset_values
    task automatic t_burst(input logic [31:0] cfg, input logic [3:0] exp);
        wr(ADDR_CLOCK, 32'h5);
        wr(ADDR_PORT_ENA, 32'h5);
        wr(ADDR_OUT_BASE, 32'h0103);
        load_active = cfg[CFG_LD_POL];
        wr(ADDR_CFG, cfg & 32'hFFFF_FFFE);
        falls = 0;
        low_cycles = 0;
        wr(ADDR_CFG, cfg);
        wait_clear(ADDR_CFG);
        rd_chk("single", ADDR_CFG, cfg & 32'hFFFF_FFFE);
        chk("shifts", 32'h4, 32'(falls));
        chk("low", 32'h14, 32'(low_cycles));
        chk("chain", {28'h0, exp}, {28'h0, par_out[3:0]});
    endtask : t_burst
    task automatic t_inputs;
        par_in = 16'hA500;
        load_active = 1'b1;
        wr(ADDR_PORT_ENA, 32'h3);
        wr(ADDR_CFG, 32'h180D);
        wait_clear(ADDR_CFG);
        wr(ADDR_CFG, 32'h180D);
        wait_clear(ADDR_CFG);
        rd_chk("inputs", ADDR_IN_BASE, 32'h5A);
        chk("los", 32'h2, {30'h0, loss_of_signal[1:0]});
    endtask : t_inputs
    task automatic t_detect;
        wr(ADDR_MAP_BASE + 8'h04, 32'h005);
        wr(ADDR_MAP_BASE + 8'h04, 32'h105);
        parallel_signal_detect_n <= 16'h0002;
        repeat (6) @(posedge clock);
        chk("det hi", 32'h3, {30'h0, loss_of_signal[5], loss_of_signal[1]});
        parallel_signal_detect_n <= 16'h0000;
        repeat (6) @(posedge clock);
        chk("det lo", 32'h1, {30'h0, loss_of_signal[5], loss_of_signal[1]});
    endtask : t_detect
    task automatic t_repeat;
        int span;
        int base;
        wr(ADDR_PORT_ENA, 32'h1);
        wr(ADDR_CFG, 32'h0852);
        wait_loads(3);
        span = t_last - t_prev;
        wr(ADDR_CFG, 32'h0840);
        wait_clear(ADDR_STATUS);
        wr(ADDR_CFG, 32'h0842);
        wait_loads(3);
        chk("gap", 32'(span + 2 * GAP_STEP), 32'(t_last - t_prev));
        wr(ADDR_CFG, 32'h0840);
        wait_clear(ADDR_STATUS);
        base = loads;
        repeat (200) @(posedge clock);
        chk("stop", 32'(base), 32'(loads));
    endtask : t_repeat
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset_values;
        t_burst(32'h0805, 4'b1110);
        t_burst(32'h2005, 4'b1011);
        t_inputs;
        t_detect;
        t_repeat;
        give_verdict;
    end
    initial
    begin
        repeat (50000) @(posedge clock);
        $display("Error watchdog expected done seen timeout");
        bad_count++;
        give_verdict;
    end
endmodule : serial_gpio_shift_controller_tb
bind serial_gpio_shift_controller serial_gpio_shift_controller_asserts #(
    .GAP_STEP_CYCLES(GAP_STEP_CYCLES)
) serial_gpio_shift_controller_asserts_inst (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chain_shift_clock(chain_shift_clock), .chain_data_out(chain_data_out),
    .chain_load_strobe(chain_load_strobe));

/* File: verification/shift_chain_model.sv */
// Board chain of load-capable shift registers.
// Assumes LEN stages and the pins wired straight to the block.
`timescale 1ns/1ps
module shift_chain_model #(
    parameter int LEN = 16
) (
    input wire logic chain_shift_clock,
    input wire logic chain_data_out,
    input wire logic chain_load_strobe,
    input wire logic load_active,
    input wire logic [LEN-1:0] par_in,
    output logic chain_data_in,
    output logic [LEN-1:0] par_out
);
    logic [LEN-1:0] out_sr = '0;
    logic [LEN-1:0] in_sr = '0;
    assign chain_data_in = in_sr[LEN-1];
    // Both registers shift on the rising shift edge
    always @(posedge chain_shift_clock)
    begin
        out_sr <= {out_sr[LEN-2:0], chain_data_out};
        in_sr <= {in_sr[LEN-2:0], ~in_sr[0]};
    end
    // Active load edge shows outputs and captures inputs
    always @(chain_load_strobe)
    begin
        if (chain_load_strobe === load_active)
        begin
            par_out <= out_sr;
            in_sr <= par_in;
        end
    end
endmodule : shift_chain_model
